// [dual_nibble_io_defs.svh]
// constants for the dual nibble i/o port: addresses, fields, resets, timing
`ifndef DUAL_NIBBLE_IO_DEFS_SVH
`define DUAL_NIBBLE_IO_DEFS_SVH

// register addresses
`define ADDR_PORT0_PIN_DATA 12'h2ed
`define ADDR_TIMER_AND_PORT0_DIRECTION 12'h2ee
`define ADDR_PORT1_PIN_DATA 12'h2fd
`define ADDR_OSCILLATOR_AND_PORT1_DIRECTION 12'h2fe

// field positions
`define DIRECTION_BIT 0

// reset values
`define LATCH_RESET 4'h0
`define DIRECTION_RESET 1'b0
`define NIBBLE_ZERO 4'h0

// direction encodings
`define DIR_INPUT 1'b0
`define DIR_OUTPUT 1'b1

// pull-down time in tenths of a cpu clock cycle (1.5 cycles)
`define PULLDOWN_TIME_TENTHS 15
// least time, rounded up to whole cycles
`define PULLDOWN_CYCLES ((`PULLDOWN_TIME_TENTHS + 9) / 10)

// default drive option: 0 push-pull, 1 high-side open drain, per pin
`define DRIVE_OPTION_DEFAULT 8'h00

`endif

// [dual_nibble_io_pkg.sv]
// types shared by the dual nibble i/o port
package dual_nibble_io_pkg;

    typedef logic [3:0] nibble_t;
    typedef logic [11:0] addr_t;
    typedef logic [1:0] pd_count_t;

    typedef enum logic {
        PD_IDLE,
        PD_ACTIVE
    } pulldown_state_e;

endpackage

// [pin_level_filter.sv]
// three-flop pin synchroniser with agreement filter for one nibble
`timescale 1ns/1ps

`include "dual_nibble_io_defs.svh"

module pin_level_filter
    import dual_nibble_io_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire dual_nibble_io_pkg::nibble_t pins_in,
    output dual_nibble_io_pkg::nibble_t level_out
);

    nibble_t stage1_r;
    nibble_t stage2_r;
    nibble_t stage3_r;
    nibble_t level_r;
    nibble_t level_nxt;

    // per bit: accept a new level once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bit
            assign level_nxt[b] = (stage2_r[b] == stage3_r[b]) ?
                                  stage3_r[b] : level_r[b];
        end
    endgenerate

    // synchroniser chain; stage one feeds stage two only
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage1_r <= `NIBBLE_ZERO;
            stage2_r <= `NIBBLE_ZERO;
            stage3_r <= `NIBBLE_ZERO;
            level_r <= `NIBBLE_ZERO;
        end else begin
            stage1_r <= pins_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule

// [dual_nibble_io_port.sv]
// two 4-bit bidirectional ports with direction, latch and read pull-down
//
// What this block does
// (RQ1) A nibble whose direction bit is 0 leaves all four pins undriven.
// (RQ2) A nibble whose direction bit is 1 drives each push-pull pin to its latch bit.
// (RQ3) Reset clears both direction bits, so every pin starts as an input.
// (RQ4) Bit 0 at 2EEH sets port 0 direction, bit 0 at 2FEH port 1; both R/W.
// (RQ5) Writes at 2EDH and 2FDH load the latch in either mode.
// (RQ6) Reads of the data registers return pin levels, never the latch.
// (RQ7) Each data read turns that port's pull-down on for 2 cycles (1.5 cycles rounded up).
// (RQ8) Reset clears both output latches.
// (RQ9) A per-pin build option picks push-pull or high-side open drain.
// (RQ11) A direction write acts on the pin drivers as the write completes.
`timescale 1ns/1ps

`include "dual_nibble_io_defs.svh"

module dual_nibble_io_port
    import dual_nibble_io_pkg::*;
#(
    // per pin: bits 3:0 port 0, bits 7:4 port 1; 1 selects open drain
    parameter logic [7:0] DRIVE_OPTION = `DRIVE_OPTION_DEFAULT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire dual_nibble_io_pkg::addr_t addr_in,
    input wire dual_nibble_io_pkg::nibble_t wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output dual_nibble_io_pkg::nibble_t rdata_out,
    input wire dual_nibble_io_pkg::nibble_t port0_pins_in,
    output dual_nibble_io_pkg::nibble_t port0_pins_out,
    output dual_nibble_io_pkg::nibble_t port0_pins_oe_n_out,
    output logic port0_pulldown_out,
    input wire dual_nibble_io_pkg::nibble_t port1_pins_in,
    output dual_nibble_io_pkg::nibble_t port1_pins_out,
    output dual_nibble_io_pkg::nibble_t port1_pins_oe_n_out,
    output logic port1_pulldown_out
);

    import dual_nibble_io_pkg::*;

    // stored state
    nibble_t port0_latch_r;
    nibble_t port1_latch_r;
    logic port0_direction_r;
    logic port1_direction_r;
    nibble_t rdata_r;
    nibble_t rdata_nxt;

    // pull-down sequencers, one per port
    pulldown_state_e pd0_state_r;
    pulldown_state_e pd1_state_r;
    pd_count_t pd0_count_r;
    pd_count_t pd1_count_r;

    // filtered pin levels
    nibble_t port0_level;
    nibble_t port1_level;

    // address decode
    wire sel_port0_data = (addr_in == `ADDR_PORT0_PIN_DATA);
    wire sel_port0_dir = (addr_in == `ADDR_TIMER_AND_PORT0_DIRECTION);
    wire sel_port1_data = (addr_in == `ADDR_PORT1_PIN_DATA);
    wire sel_port1_dir = (addr_in == `ADDR_OSCILLATOR_AND_PORT1_DIRECTION);

    // write and read strobes per register
    wire wr_port0_data = wr_in & sel_port0_data;
    wire wr_port0_dir = wr_in & sel_port0_dir;
    wire wr_port1_data = wr_in & sel_port1_data;
    wire wr_port1_dir = wr_in & sel_port1_dir;
    wire rd_port0_data = rd_in & sel_port0_data;
    wire rd_port1_data = rd_in & sel_port1_data;

    // pull-down length as a counter value
    localparam pd_count_t PD_LAST = pd_count_t'(`PULLDOWN_CYCLES - 1);

    // pin sampling
    pin_level_filter u_port0_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .pins_in(port0_pins_in),
        .level_out(port0_level)
    );

    pin_level_filter u_port1_filter (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .pins_in(port1_pins_in),
        .level_out(port1_level)
    );

    // read mux: pin levels for data, direction bit for control
    always_comb begin
        rdata_nxt = `NIBBLE_ZERO;
        if (rd_in && sel_port0_data) begin
            rdata_nxt = port0_level; // [RQ6]
        end else if (rd_in && sel_port1_data) begin
            rdata_nxt = port1_level; // [RQ6]
        end else if (rd_in && sel_port0_dir) begin
            rdata_nxt[`DIRECTION_BIT] = port0_direction_r; // [RQ4]
        end else if (rd_in && sel_port1_dir) begin
            rdata_nxt[`DIRECTION_BIT] = port1_direction_r; // [RQ4]
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_r <= `NIBBLE_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;

    // output latches, written in either direction mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            port0_latch_r <= `LATCH_RESET; // [RQ8]
            port1_latch_r <= `LATCH_RESET; // [RQ8]
        end else begin
            if (wr_port0_data) begin
                port0_latch_r <= wdata_in; // [RQ5]
            end
            if (wr_port1_data) begin
                port1_latch_r <= wdata_in; // [RQ5]
            end
        end
    end

    // direction bits; timer and oscillator bits are not held here
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            port0_direction_r <= `DIRECTION_RESET; // [RQ3]
            port1_direction_r <= `DIRECTION_RESET; // [RQ3]
        end else begin
            if (wr_port0_dir) begin
                port0_direction_r <= wdata_in[`DIRECTION_BIT]; // [RQ4] [RQ11]
            end
            if (wr_port1_dir) begin
                port1_direction_r <= wdata_in[`DIRECTION_BIT]; // [RQ4] [RQ11]
            end
        end
    end

    // pin drivers per bit: open drain drives only a latched 1
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_drive
            wire drive0 = (port0_direction_r == `DIR_OUTPUT) &
                          (~DRIVE_OPTION[b] | port0_latch_r[b]); // [RQ9]
            wire drive1 = (port1_direction_r == `DIR_OUTPUT) &
                          (~DRIVE_OPTION[b + 4] | port1_latch_r[b]); // [RQ9]
            assign port0_pins_oe_n_out[b] = ~drive0; // [RQ1] [RQ2]
            assign port1_pins_oe_n_out[b] = ~drive1; // [RQ1] [RQ2]
        end
    endgenerate

    // driven level is the latch itself, straight from flops
    assign port0_pins_out = port0_latch_r; // [RQ2]
    assign port1_pins_out = port1_latch_r; // [RQ2]

    // port 0 pull-down: on for whole cycles after each data read
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pd0_state_r <= PD_IDLE;
            pd0_count_r <= '0;
        end else begin
            case (pd0_state_r)
                PD_IDLE: begin
                    if (rd_port0_data) begin
                        pd0_state_r <= PD_ACTIVE; // [RQ7]
                        pd0_count_r <= '0;
                    end
                end
                PD_ACTIVE: begin
                    if (rd_port0_data) begin
                        pd0_count_r <= '0; // [RQ7]
                    end else if (pd0_count_r == PD_LAST) begin
                        pd0_state_r <= PD_IDLE; // [RQ7]
                    end else begin
                        pd0_count_r <= pd0_count_r + 2'd1;
                    end
                end
                default: begin
                    pd0_state_r <= PD_IDLE;
                end
            endcase
        end
    end

    // port 1 pull-down, same sequence
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pd1_state_r <= PD_IDLE;
            pd1_count_r <= '0;
        end else begin
            case (pd1_state_r)
                PD_IDLE: begin
                    if (rd_port1_data) begin
                        pd1_state_r <= PD_ACTIVE; // [RQ7]
                        pd1_count_r <= '0;
                    end
                end
                PD_ACTIVE: begin
                    if (rd_port1_data) begin
                        pd1_count_r <= '0; // [RQ7]
                    end else if (pd1_count_r == PD_LAST) begin
                        pd1_state_r <= PD_IDLE; // [RQ7]
                    end else begin
                        pd1_count_r <= pd1_count_r + 2'd1;
                    end
                end
                default: begin
                    pd1_state_r <= PD_IDLE;
                end
            endcase
        end
    end

    // pull-down enables come straight from state flops
    assign port0_pulldown_out = (pd0_state_r == PD_ACTIVE);
    assign port1_pulldown_out = (pd1_state_r == PD_ACTIVE);

endmodule

// [dual_nibble_io_properties.sv]
// assertion checker for the dual nibble i/o port
`timescale 1ns/1ps
module dual_nibble_io_checker #(
    parameter logic [7:0] DRIVE_OPTION = 8'h00
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [11:0] addr_in,
    input wire logic [3:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [3:0] rdata_out,
    input wire logic [3:0] port0_pins_out,
    input wire logic [3:0] port0_pins_oe_n_out,
    input wire logic port0_pulldown_out
);
    // decoded port 0 bus cycles
    wire rd0 = rd_in && addr_in == 12'h2ed;
    wire wl0 = wr_in && addr_in == 12'h2ed;
    wire wd0 = wr_in && addr_in == 12'h2ee;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // read pull-down, latch, drivers, read data
    a_pd0_pulse: assert property (rd0 |=> port0_pulldown_out [*2])
        else $error("port0 pull-down too short");
    a_pd0_end: assert property ((!rd0) [*2] |=> !port0_pulldown_out)
        else $error("port0 pull-down too long");
    a_latch_load: assert property (
        wl0 |=> port0_pins_out == $past(wdata_in))
        else $error("port0 latch not loaded");
    a_latch_hold: assert property (!wl0 |=> $stable(port0_pins_out))
        else $error("port0 latch changed");
    a_dir_effect: assert property (
        wd0 |=> port0_pins_oe_n_out == ({4{~$past(wdata_in[0])}}
        | (DRIVE_OPTION[3:0] & ~port0_pins_out)))
        else $error("port0 drivers miss direction");
    a_oe_hold: assert property (
        !wd0 && !wl0 |=> $stable(port0_pins_oe_n_out))
        else $error("port0 drivers changed");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 4'h0)
        else $error("read data outside read cycle");
    a_reset_state: assert property (
        $fell(sys_rst_in) |-> port0_pins_oe_n_out == 4'hf
        && port0_pins_out == 4'h0)
        else $error("port0 not cleared by reset");
    // main scenarios reached
    c_read0: cover property (rd0 ##1 rd_in);
    c_out_mode: cover property (wd0 && wdata_in[0]);
    c_in_mode: cover property (wd0 && !wdata_in[0]);
endmodule

bind dual_nibble_io_port dual_nibble_io_checker #(
    .DRIVE_OPTION(DRIVE_OPTION)
) dual_nibble_io_checker_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .port0_pins_out(port0_pins_out),
    .port0_pins_oe_n_out(port0_pins_oe_n_out),
    .port0_pulldown_out(port0_pulldown_out)
);

// [pin_circuit.sv]
// external circuitry on one nibble of pins
`timescale 1ns/1ps
module pin_circuit (
    input wire logic clk_in,
    input wire logic [3:0] drive_in,
    input wire logic [3:0] oe_n_in,
    input wire logic pulldown_in,
    input wire logic load_en_in,
    input wire logic [3:0] load_in,
    output logic [3:0] level_out
);
    logic [3:0] float_r = 4'h0;
    // an undriven pin wanders each cycle
    always @(posedge clk_in) float_r <= ~float_r;
    // strong load wins, then the port driver, then the pull-down
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (load_en_in) level_out[i] = load_in[i];
            else if (!oe_n_in[i]) level_out[i] = drive_in[i];
            else if (pulldown_in) level_out[i] = 1'b0;
            else level_out[i] = float_r[i];
        end
    end
endmodule

// [dual_nibble_io_port_test.sv]
// self-checking bench for the dual nibble i/o port
`timescale 1ns/1ps
module dual_nibble_io_port_test;
    import dual_nibble_io_pkg::*;
    // port, dir, latch, load on, load, pins read back
    typedef struct packed {
        logic p, dir;
        nibble_t lat;
        logic ld_en;
        nibble_t ld, exp;
    } row_s;
    localparam logic [7:0] OD = 8'h30;
    row_s rows [7] = '{
        '{1'b0, 1'b1, 4'ha, 1'b0, 4'h0, 4'ha},
        '{1'b0, 1'b0, 4'h5, 1'b1, 4'h3, 4'h3},
        '{1'b0, 1'b1, 4'h5, 1'b0, 4'h0, 4'h5},
        '{1'b1, 1'b1, 4'h3, 1'b0, 4'h0, 4'h3},
        '{1'b1, 1'b1, 4'hc, 1'b1, 4'hc, 4'hc},
        '{1'b1, 1'b0, 4'h9, 1'b1, 4'h6, 4'h6},
        '{1'b0, 1'b1, 4'hf, 1'b1, 4'h6, 4'h6}
    };
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic pd0, pd1;
    logic [1:0] ld_en = 2'b00;
    addr_t addr_in = 12'h000;
    nibble_t wdata_in = 4'h0;
    nibble_t ld = 4'h0;
    nibble_t rdata_out, got, od, lv0, lv1, out0, out1, oe0, oe1;
    int n_errors = 0;
    int checks = 0;
    row_s r;

    dual_nibble_io_port #(.DRIVE_OPTION(OD)) dual_nibble_io_port_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .port0_pins_in(lv0), .port0_pins_out(out0),
        .port0_pins_oe_n_out(oe0), .port0_pulldown_out(pd0),
        .port1_pins_in(lv1), .port1_pins_out(out1),
        .port1_pins_oe_n_out(oe1), .port1_pulldown_out(pd1));
    pin_circuit pin_circuit_0_i (.clk_in(clk_in), .drive_in(out0),
        .oe_n_in(oe0), .pulldown_in(pd0), .load_en_in(ld_en[0]),
        .load_in(ld), .level_out(lv0));
    pin_circuit pin_circuit_1_i (.clk_in(clk_in), .drive_in(out1),
        .oe_n_in(oe1), .pulldown_in(pd1), .load_en_in(ld_en[1]),
        .load_in(ld), .level_out(lv1));

    // 250 MHz clock
    initial forever #2 clk_in = ~clk_in;

    task automatic chk(input string what, input nibble_t e, input nibble_t s);
        checks++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, s);
            n_errors++;
        end
    endtask
    task automatic bus_wr(input addr_t a, input nibble_t d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic bus_rd(input addr_t a, output nibble_t d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic print_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // reset, table rows, then back-to-back reads and a second reset
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        bus_rd(12'h2fe, got);
        chk("dir1 reset", 4'h0, got);
        chk("oe1 reset", 4'hf, oe1);
        chk("latch1 reset", 4'h0, out1);
        foreach (rows[i]) begin
            r = rows[i];
            od = r.p ? OD[7:4] : OD[3:0];
            bus_wr(r.p ? 12'h2fd : 12'h2ed, r.lat);
            bus_wr(r.p ? 12'h2fe : 12'h2ee, {3'h0, r.dir});
            bus_rd(r.p ? 12'h2fe : 12'h2ee, got);
            chk("dir", {3'h0, r.dir}, got);
            @(posedge clk_in);
            ld_en[r.p] <= r.ld_en;
            ld <= r.ld;
            repeat (6) @(posedge clk_in);
            #1 chk("oe", {4{~r.dir}} | (od & ~r.lat),
                r.p ? oe1 : oe0);
            chk("latch", r.lat, r.p ? out1 : out0);
            bus_rd(r.p ? 12'h2fd : 12'h2ed, got);
            chk("pins", r.exp, got);
        end
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= 12'h2fd;
        @(posedge clk_in);
        addr_in <= 12'h2fe;
        #1 chk("pd1 first", 4'h1, {3'h0, pd1});
        chk("port1 pins", 4'h6, rdata_out);
        @(posedge clk_in);
        addr_in <= 12'h2ff;
        #1 chk("pd1 second", 4'h1, {3'h0, pd1});
        chk("pd0 idle", 4'h0, {3'h0, pd0});
        chk("dir1 back", 4'h0, rdata_out);
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("pd1 off", 4'h0, {3'h0, pd1});
        chk("unmapped read", 4'h0, rdata_out);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1 chk("oe0 reset", 4'hf, oe0);
        chk("latch0 reset", 4'h0, out0);
        bus_wr(12'h2ee, 4'hf);
        bus_rd(12'h2ee, got);
        chk("dir0 bits", 4'h1, got);
        chk("oe0 out", 4'h0, oe0);
        print_verdict();
    end

    // watchdog: the rows need about 105 cycles, allow far more
    initial begin
        repeat (2000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end
endmodule
